// ---- rtl/aeq_pkg.sv ----
// package: register map, tables and types of the audio equalizer core
// Notes on behaviour
// - band out = half sum plus K0 half difference
// - second-order recursive all-pass using K1, K2
// - bands run serially A first, E last
// - scale bit 1 attenuates band by 6 dB
// - word1: t1, 11-bit mantissa, 4-bit exponent
// - word2: t2, mantissa, exponent, k0, scale bit
// - k values are mantissa fraction times 2^-E
// - K = 1-k when t=0, k-1 when t=1
// - band gain -30..+12 dB, Q to 8
// - bass, treble first-order shelves, 2 dB steps
// - tone gain changes obey zero-cross setting
// - corner codes 00-10, 11 reserved, reset 01
// - corner depends on code and rate family
// - soft mute raised-cosine ramp over 128 samples
// - soft unmute matching raised-cosine rise
// - hard mute blocks input, outputs 50% pulses
// - hard mute overrides soft mute
// - volume 00h +24 dB, 0.5 dB steps
// - codes BDh-FFh mute, reset BDh
// - volume changes obey zero-cross setting
// - zero-cross on: gains change only at crossing
package aeq_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0]  AEQ_CTRL_OFS   = 8'h00;	// mute and update control
	localparam logic [7:0]  AEQ_VOL_OFS    = 8'h04;	// volume code
	localparam logic [7:0]  AEQ_TONE_OFS   = 8'h08;	// bass and treble settings
	localparam logic [7:0]  AEQ_STAT_OFS   = 8'h0C;	// read-only state
	localparam logic [7:0]  AEQ_BAND_OFS   = 8'h10;	// band A words, then B..E
	localparam int          AEQ_BANDS      = 5;
	localparam int          AEQ_CTRL_SOFT  = 0;	// soft mute enable
	localparam int          AEQ_CTRL_HARD  = 1;	// hard mute enable
	localparam int          AEQ_CTRL_ZC    = 2;	// zero_cross_update_enable
	localparam logic [7:0]  AEQ_VOL_RST    = 8'hBD;	// muted after reset
	localparam logic [7:0]  AEQ_VOL_MUTE   = 8'hBD;	// first muting code
	localparam logic [23:0] AEQ_TONE_RST   = 24'h050000;	// both corners 01, 0 dB
	localparam logic [15:0] AEQ_WORD1_RST  = 16'h4000;	// K1 = 0.5
	localparam logic [15:0] AEQ_WORD2_RST  = 16'h4040;	// K2 = 0.5, K0 = 1, flat
	localparam logic [1:0]  AEQ_OKAY       = 2'h0;
	localparam logic [1:0]  AEQ_SLVERR     = 2'h2;
	// ---------------------------------------------------------------
	// arithmetic constants and tables
	// ---------------------------------------------------------------
	localparam logic signed [17:0] AEQ_ONE_Q14 = 18'sh04000;
	localparam int AEQ_RAMP_LEN   = 128;	// soft mute length in samples
	localparam int AEQ_TWO_PI_Q14 = 102944;	// 2*pi in Q14
	// fc per code (00,01,10) and family (8k, 11.025k, 12k bases)
	localparam int AEQ_BASS_HZ [0:8] = '{181, 250, 272, 218, 300, 326, 300, 413, 450};
	localparam int AEQ_TREB_HZ [0:8] = '{1090, 1500, 1630, 2180, 3000, 3260, 3000, 4130, 4500};
	localparam int AEQ_FS_BASE [0:2] = '{8000, 11025, 12000};
	// shelf gain, -18..+18 dB in 2 dB steps, Q12
	localparam int AEQ_SHELF_GAIN [0:18] = '{516, 650, 818, 1029, 1295, 1631, 2053, 2584,
		3254, 4096, 5157, 6492, 8173, 10289, 12953, 16306, 20529, 25844, 32535};
	// volume fraction per 0.5 dB within a 6 dB octave, Q15
	localparam int AEQ_VOL_FRAC [0:11] = '{32768, 30935, 29205, 27571, 26029, 24573,
		23198, 21900, 20675, 19519, 18427, 17396};
	// raised-cosine soft mute gain, 17 points, Q15
	localparam int AEQ_RAMP_GAIN [0:16] = '{0, 315, 1247, 2761, 4799, 7282, 10114, 13188,
		16384, 19580, 22654, 25486, 27969, 30007, 31521, 32453, 32768};
	typedef enum logic [4:0] {
		AEQ_ST_IDLE = 5'b00001,
		AEQ_ST_EQ   = 5'b00010,
		AEQ_ST_TONE = 5'b00100,
		AEQ_ST_VOL  = 5'b01000,
		AEQ_ST_OUT  = 5'b10000
	} aeq_state_t;
endpackage

// ---- rtl/aeq_core.sv ----
// audio equalizer, tone, mute and volume datapath with an AXI4-Lite slave
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module aeq_core
	import aeq_pkg::*;
#(
	parameter int BANDS = AEQ_BANDS	// equalizer sections in the cascade
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic signed [15:0] sampleIn,
	input  wire logic               sampleInValid,
	output logic                    sampleInReady,
	output logic signed [15:0]      sampleOut,
	output logic                    sampleOutValid,
	output logic                    muteSquare
);
	// ---------------------------------------------------------------
	// helper functions
	// ---------------------------------------------------------------
	// clamp to 16-bit full scale, wrapping would cause loud clicks
	function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
		if (v > 48'sh7FFF) return 16'sh7FFF;
		if (v < -48'sh8000) return 16'sh8000;
		return v[15:0];
	endfunction
	// word-aligned and inside the map
	function automatic logic addrHit(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a < 8'(AEQ_BAND_OFS + 8'(4 * BANDS)));
	endfunction
	function automatic logic [31:0] mergeBytes(input logic [31:0] o, n, input logic [3:0] s);
		for (int b = 0; b < 4; b++) if (s[b]) o[8*b +: 8] = n[8*b +: 8];
		return o;
	endfunction
	// reserved corner 11 falls back to 01, reserved family to the 8 kHz base
	function automatic int cornerIdx(input logic [1:0] code, input logic [1:0] fam);
		return 3 * ((code == 2'h3) ? 1 : int'(code)) + ((fam == 2'h3) ? 0 : int'(fam));
	endfunction
	// tone gain code is signed steps of 2 dB, clamped to +-9 steps
	function automatic int shelfIdx(input logic signed [4:0] c);
		if (c > 5'sd9) return 18;
		if (c < -5'sd9) return 0;
		return int'(c) + 9;
	endfunction
	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic [2:0]        ctrlReg;	// soft, hard, zero-cross bits
	logic [7:0]        volReg;	// volume code as written
	logic [23:0]       toneReg;	// bass/treble gains, corners, rate
	logic [31:0]       coefShadow [BANDS];	// words as written by software
	logic [31:0]       coefActive [BANDS];	// words in use for this sample
	logic              awHeld, wHeld;	// address / data captured
	logic [7:0]        awAddrQ;
	logic [31:0]       wDataQ;
	logic [3:0]        wStrbQ;
	aeq_state_t        state, next_state;
	logic [2:0]        bandIdx;	// band being computed, 0 = A
	logic signed [15:0] work;	// sample moving through the chain
	logic signed [15:0] prevIn;	// last input, for crossing detect
	logic signed [15:0] dX1 [BANDS], dX2 [BANDS], dY1 [BANDS], dY2 [BANDS];
	logic signed [15:0] lpBass, lpTreb;	// one-pole low-pass states
	logic [7:0]        volApplied;	// gains in force after zero-cross gating
	logic signed [4:0] bassApplied, trebApplied;
	logic [7:0]        rampPos;	// soft mute position, 128 = full gain
	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire logic ctrlSoft   = ctrlReg[AEQ_CTRL_SOFT];
	wire logic ctrlHard   = ctrlReg[AEQ_CTRL_HARD];
	wire logic ctrlZc     = ctrlReg[AEQ_CTRL_ZC];
	wire logic awTake     = s_axi_awvalid & s_axi_awready;
	wire logic wTake      = s_axi_wvalid & s_axi_wready;
	wire logic arTake     = s_axi_arvalid & s_axi_arready;
	wire logic doWrite    = awHeld & wHeld & ~s_axi_bvalid;	// both halves in, reply free
	wire logic next_awHeld = ~doWrite & (awHeld | awTake);
	wire logic next_wHeld  = ~doWrite & (wHeld | wTake);
	wire logic next_rvalid = arTake | (s_axi_rvalid & ~s_axi_rready);
	wire logic [2:0] wrBand = 3'((awAddrQ - AEQ_BAND_OFS) >> 2);
	wire logic [2:0] rdBand = 3'((s_axi_araddr - AEQ_BAND_OFS) >> 2);
	wire logic [31:0] statWord = {14'h0000, ctrlHard, (state != AEQ_ST_IDLE), rampPos,
		volApplied};
	wire logic [31:0] rdMux =
		(s_axi_araddr == AEQ_CTRL_OFS) ? {29'h0, ctrlReg} :
		(s_axi_araddr == AEQ_VOL_OFS)  ? {24'h0, volReg} :
		(s_axi_araddr == AEQ_TONE_OFS) ? {8'h00, toneReg} :
		(s_axi_araddr == AEQ_STAT_OFS) ? statWord :
		(s_axi_araddr >= AEQ_BAND_OFS) ? coefShadow[rdBand] : 32'h0;
	// ---------------------------------------------------------------
	// bus handshakes
	// ---------------------------------------------------------------
	// one write and one read in flight; ready drops while a half is held
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{awHeld, wHeld, s_axi_awready, s_axi_wready} <= 4'h0;
			{s_axi_bvalid, s_axi_arready, s_axi_rvalid} <= 3'h0;
			s_axi_bresp <= AEQ_OKAY;
			s_axi_rresp <= AEQ_OKAY;
			s_axi_rdata <= 32'h0;
			awAddrQ <= 8'h00;
			wDataQ <= 32'h0;
			wStrbQ <= 4'h0;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			s_axi_awready <= ~next_awHeld;
			s_axi_wready <= ~next_wHeld;
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid <= next_rvalid;
			if (awTake) awAddrQ <= s_axi_awaddr;
			if (wTake) begin
				wDataQ <= s_axi_wdata;
				wStrbQ <= s_axi_wstrb;
			end
			// unmapped or misaligned addresses answer SLVERR and store nothing
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addrHit(awAddrQ) ? AEQ_OKAY : AEQ_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (arTake) begin
				s_axi_rdata <= addrHit(s_axi_araddr) ? rdMux : 32'h0;
				s_axi_rresp <= addrHit(s_axi_araddr) ? AEQ_OKAY : AEQ_SLVERR;
			end
		end
	end
	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrlReg <= 3'h0;
			volReg <= AEQ_VOL_RST;
			toneReg <= AEQ_TONE_RST;	// corner codes reset to 01
			for (int i = 0; i < BANDS; i++) coefShadow[i] <= {AEQ_WORD2_RST, AEQ_WORD1_RST};
		end else if (doWrite && addrHit(awAddrQ)) begin
			// coefficient, volume and tone gain writes land in shadows; the datapath picks them up per sample
			if (awAddrQ == AEQ_CTRL_OFS) ctrlReg <= 3'(mergeBytes({29'h0, ctrlReg}, wDataQ, wStrbQ));
			if (awAddrQ == AEQ_VOL_OFS) volReg <= 8'(mergeBytes({24'h0, volReg}, wDataQ, wStrbQ));
			if (awAddrQ == AEQ_TONE_OFS) toneReg <= 24'(mergeBytes({8'h0, toneReg}, wDataQ, wStrbQ));
			if (awAddrQ >= AEQ_BAND_OFS) coefShadow[wrBand] <= mergeBytes(coefShadow[wrBand],
				wDataQ, wStrbQ);
		end
	end
	// ---------------------------------------------------------------
	// coefficient unpacking
	// ---------------------------------------------------------------
	logic signed [17:0] kOne [BANDS];	// K1, Q14
	logic signed [17:0] kTwo [BANDS];	// K2, Q14
	logic [6:0]         kZero [BANDS];	// K0, unsigned Q2.5
	logic               bandScaleBit [BANDS];
	logic [32*BANDS-1:0] coefFlat;	// active words side by side, for the swap check
	genvar gi;
	generate
		for (gi = 0; gi < BANDS; gi++) begin : g_unpack
			logic [15:0] wOne, wTwo;
			logic signed [17:0] kOneP, kTwoP;	// k1', k2' in Q14
			assign wOne = coefActive[gi][15:0];
			assign wTwo = coefActive[gi][31:16];
			// mantissa is a fraction below one, scaled by 2^-E
			assign kOneP = (18'(wOne[14:4]) <<< 3) >>> wOne[3:0];
			assign kTwoP = (18'(wTwo[14:11]) <<< 10) >>> wTwo[10:8];
			// t flag picks which side of one the value sits
			assign kOne[gi] = wOne[15] ? kOneP - AEQ_ONE_Q14 : AEQ_ONE_Q14 - kOneP;
			assign kTwo[gi] = wTwo[15] ? kTwoP - AEQ_ONE_Q14 : AEQ_ONE_Q14 - kTwoP;
			// Q2.5 tops out just under 4, the +12 dB band ceiling
			assign kZero[gi] = wTwo[7:1];
			assign bandScaleBit[gi] = wTwo[0];
			assign coefFlat[32*gi +: 32] = coefActive[gi];
		end
	endgenerate
	// ---------------------------------------------------------------
	// band arithmetic, one band per cycle
	// ---------------------------------------------------------------
	wire logic signed [17:0] curK1 = kOne[bandIdx];
	wire logic signed [17:0] curK2 = kTwo[bandIdx];
	wire logic signed [7:0]  curK0 = {1'b0, kZero[bandIdx]};
	// widen before the product, a self-sized multiply would keep only 18 bits
	wire logic signed [19:0] curA1 = 20'((36'(curK2) * (36'(AEQ_ONE_Q14) + 36'(curK1)))
		>>> 14);
	logic signed [47:0] apAcc, bandAcc;
	logic signed [15:0] apOut, bandOut;
	// all-pass A(z) in direct form, delays hold one sample
	assign apAcc = curK1 * work + curA1 * dX1[bandIdx] + (48'(dX2[bandIdx]) <<< 14)
		- curA1 * dY1[bandIdx] - curK1 * dY2[bandIdx];
	assign apOut = sat16(apAcc >>> 14);
	// (x+A)/2 + K0*(x-A)/2 with K0 in Q5, so both halves share a 2^-6
	assign bandAcc = ((48'(work) + apOut) <<< 5) + (48'(work) - apOut) * curK0;
	// scale bit adds one more halving, headroom for boosts
	assign bandOut = sat16(bandAcc >>> (bandScaleBit[bandIdx] ? 7 : 6));
	// ---------------------------------------------------------------
	// tone and volume arithmetic
	// ---------------------------------------------------------------
	// corner alpha = 2*pi*fc/fs, halved per doubling of the base rate
	wire logic signed [31:0] alphaBass =
		(AEQ_BASS_HZ[cornerIdx(toneReg[17:16], toneReg[21:20])]
		* AEQ_TWO_PI_Q14 / AEQ_FS_BASE[cornerIdx(2'h0, toneReg[21:20])]) >>> toneReg[23:22];
	wire logic signed [31:0] alphaTreb =
		(AEQ_TREB_HZ[cornerIdx(toneReg[19:18], toneReg[21:20])]
		* AEQ_TWO_PI_Q14 / AEQ_FS_BASE[cornerIdx(2'h0, toneReg[21:20])]) >>> toneReg[23:22];
	wire logic signed [15:0] next_lpBass = sat16(48'(lpBass) + ((alphaBass * (48'(work)
		- lpBass)) >>> 14));
	wire logic signed [15:0] next_lpTreb = sat16(48'(lpTreb) + ((alphaTreb * (48'(work)
		- lpTreb)) >>> 14));
	// shelves add (g-1) times the low band or the high band
	wire logic signed [15:0] toneOut = sat16(48'(work)
		+ (((AEQ_SHELF_GAIN[shelfIdx(bassApplied)] - 4096) * next_lpBass) >>> 12)
		+ (((AEQ_SHELF_GAIN[shelfIdx(trebApplied)] - 4096) * (48'(work) - next_lpTreb)) >>> 12));
	// gain = 2^(4-q) * 10^(-r/40) where code = 12q + r
	wire logic [4:0] volQuot = 5'(volApplied / 8'h0C);
	wire logic [3:0] volRem = 4'(volApplied % 8'h0C);
	wire logic [5:0] volShift = 6'(volQuot + 5'h0B);
	wire logic signed [15:0] volOut = (volApplied >= AEQ_VOL_MUTE) ? 16'sh0000 :
		sat16((48'(work) * AEQ_VOL_FRAC[volRem]) >>> volShift);
	wire logic signed [15:0] softOut = sat16((48'(work)
		* AEQ_RAMP_GAIN[rampPos[7:3]]) >>> 15);
	// ---------------------------------------------------------------
	// sequencing
	// ---------------------------------------------------------------
	wire logic sampleTake = sampleInValid & sampleInReady;
	wire logic crossing = (sampleIn[15] != prevIn[15]) | (sampleIn == 16'sh0000);
	wire logic gainUpdate = ~ctrlZc | crossing;
	wire logic lastBand = (bandIdx == 3'(BANDS - 1));
	always_comb begin
		next_state = state;
		case (state)
			AEQ_ST_IDLE: if (sampleTake) next_state = AEQ_ST_EQ;
			AEQ_ST_EQ:   if (lastBand) next_state = AEQ_ST_TONE;
			AEQ_ST_TONE: next_state = AEQ_ST_VOL;
			AEQ_ST_VOL:  next_state = AEQ_ST_OUT;
			AEQ_ST_OUT:  next_state = AEQ_ST_IDLE;
			default:     next_state = AEQ_ST_IDLE;
		endcase
	end
	// state, band counter and the sample word
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= AEQ_ST_IDLE;
			bandIdx <= 3'h0;
			work <= 16'sh0000;
			sampleInReady <= 1'b0;
		end else begin
			state <= next_state;
			sampleInReady <= (next_state == AEQ_ST_IDLE);	// samples during work wait
			bandIdx <= (state == AEQ_ST_EQ) ? 3'(bandIdx + 3'h1) : 3'h0;	// A to E
			case (state)
				AEQ_ST_IDLE: if (sampleTake) work <= sampleIn;
				AEQ_ST_EQ:   work <= bandOut;	// each band feeds the next
				AEQ_ST_TONE: work <= toneOut;
				AEQ_ST_VOL:  work <= volOut;
				default:     work <= work;
			endcase
		end
	end
	// filter memories and coefficient swap
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < BANDS; i++) begin
				{dX1[i], dX2[i], dY1[i], dY2[i]} <= 64'h0;
				coefActive[i] <= {AEQ_WORD2_RST, AEQ_WORD1_RST};
			end
			{lpBass, lpTreb} <= 32'h0;
		end else begin
			if (sampleTake) coefActive <= coefShadow;	// only between samples
			if (state == AEQ_ST_EQ) begin
				dX2[bandIdx] <= dX1[bandIdx];
				dX1[bandIdx] <= work;
				dY2[bandIdx] <= dY1[bandIdx];
				dY1[bandIdx] <= apOut;
			end
			if (state == AEQ_ST_TONE) begin
				lpBass <= next_lpBass;
				lpTreb <= next_lpTreb;
			end
		end
	end
	// gains in force, gated by the zero-crossing option
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prevIn <= 16'sh0000;
			volApplied <= AEQ_VOL_RST;
			{bassApplied, trebApplied} <= 10'h000;
		end else if (sampleTake) begin
			prevIn <= sampleIn;
			if (gainUpdate) begin
				volApplied <= volReg;
				bassApplied <= toneReg[4:0];
				trebApplied <= toneReg[12:8];
			end
		end
	end
	// output, soft mute ramp and hard mute square wave
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sampleOut <= 16'sh0000;
			sampleOutValid <= 1'b0;
			rampPos <= 8'(AEQ_RAMP_LEN);
			muteSquare <= 1'b0;
		end else begin
			sampleOutValid <= (state == AEQ_ST_OUT);
			muteSquare <= ctrlHard ? ~muteSquare : 1'b0;	// 50 % duty
			if (state == AEQ_ST_OUT) begin
				sampleOut <= ctrlHard ? 16'sh0000 : softOut;	// hard wins
				if (ctrlSoft && rampPos != 8'h00) rampPos <= 8'(rampPos - 8'h01);
				else if (!ctrlSoft && rampPos != 8'(AEQ_RAMP_LEN))
					rampPos <= 8'(rampPos + 8'h01);
			end
		end
	end
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	hard_mute_out_a: assert property (state == AEQ_ST_OUT && ctrlHard |=> sampleOutValid && sampleOut == 16'sh0000) else $error("hard mute leaked audio");
	square_wave_a: assert property (ctrlHard |=> muteSquare != $past(muteSquare)) else $error("mute square not toggling");
	vol_mute_a: assert property (state == AEQ_ST_VOL && volApplied >= 8'hBD ##1 ctrlHard == 1'b0 |=> sampleOut == 16'sh0000) else $error("mute code passed audio");
	ramp_down_a: assert property (state == AEQ_ST_OUT && ctrlSoft && rampPos != 8'h00 |=> rampPos == 8'($past(rampPos) - 8'h01)) else $error("soft mute ramp stalled");
	ramp_up_a: assert property (state == AEQ_ST_OUT && !ctrlSoft && rampPos < 8'h80 |=> rampPos == 8'($past(rampPos) + 8'h01)) else $error("soft unmute ramp stalled");
	zc_hold_a: assert property (sampleTake && ctrlZc && !crossing |=> $stable(volApplied) && $stable(bassApplied)) else $error("gain moved off a crossing");
	vol_update_a: assert property (sampleTake && !ctrlZc |=> volApplied == $past(volReg)) else $error("volume not applied");
	coef_stable_a: assert property (state != AEQ_ST_IDLE && $past(state) != AEQ_ST_IDLE
		|-> $stable(coefFlat)) else $error("coefficients changed mid sample");
	band_order_a: assert property (state == AEQ_ST_EQ && !lastBand |=> state == AEQ_ST_EQ && bandIdx == 3'($past(bandIdx) + 3'h1)) else $error("band order broken");
	chain_end_a: assert property (state == AEQ_ST_EQ && lastBand |=> state == AEQ_ST_TONE ##1 state == AEQ_ST_VOL ##1 state == AEQ_ST_OUT ##1 sampleOutValid) else $error("chain tail out of order");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	write_resp_a: assert property (awTake && wTake && !s_axi_bvalid
		|=> ##1 s_axi_bvalid) else $error("write response late");
	soft_floor_c: cover property (state == AEQ_ST_OUT && rampPos == 8'h01 && ctrlSoft);
	hard_out_c: cover property (sampleOutValid && ctrlHard);
	zc_update_c: cover property (sampleTake && ctrlZc && crossing && volReg != volApplied);
	bad_addr_c: cover property (s_axi_bvalid && s_axi_bresp == AEQ_SLVERR);
endmodule // aeq_core

// ---- bench/aeq_sample_source.sv ----
// sample source and sink standing in for the serial audio front end
`timescale 1ns/1ps
module aeq_sample_source (
	input  wire logic               clk,
	output logic signed [15:0]      sampleIn,
	output logic                    sampleInValid,
	input  wire logic               sampleInReady,
	input  wire logic signed [15:0] sampleOut,
	input  wire logic               sampleOutValid
);
	initial begin
		sampleIn = 16'sh0000;
		sampleInValid = 1'b0;
	end
	// offer one sample, hold it until taken, then wait for its result
	task automatic send(input logic signed [15:0] v, output logic signed [15:0] o);
		logic taken;
		@(posedge clk);
		sampleIn <= v;
		sampleInValid <= 1'b1;
		do begin
			@(negedge clk);
			taken = sampleInValid & sampleInReady;
			@(posedge clk);
		end while (!taken);
		sampleInValid <= 1'b0;
		sampleIn <= ~v;	// released line must not keep a stale value
		// a lost result hangs here until the bench's cycle ceiling counts it
		while (sampleOutValid !== 1'b1) @(negedge clk);
		o = sampleOut;
	endtask
endmodule // aeq_sample_source

// ---- bench/aeq_core_test.sv ----
// self-checking bench of the equalizer, mute and volume core
`timescale 1ns/1ps
module aeq_core_test;
	import aeq_pkg::*;
	logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp, resp;
	logic awready, wready, bvalid, arready, rvalid, outValid, inValid, inReady, sq, sq0;
	logic signed [15:0] sIn, sOut, res;
	logic [31:0] rd;
	int failures = 0, n_tests = 0, cycles = 0;
	always #4 clk = ~clk;
	aeq_core aeq_core_inst (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sampleIn(sIn), .sampleInValid(inValid),
		.sampleInReady(inReady), .sampleOut(sOut), .sampleOutValid(outValid),
		.muteSquare(sq));
	aeq_sample_source aeq_sample_source_inst (.clk(clk), .sampleIn(sIn),
		.sampleInValid(inValid), .sampleInReady(inReady), .sampleOut(sOut),
		.sampleOutValid(outValid));
	task automatic conclude();
		$display("compares %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			conclude();
		end
	end
	task automatic checkEq(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// datapath rounding allowed: within 2 % plus a few lsb
	task automatic checkNear(input logic signed [15:0] g, input int e);
		n_tests++;
		if ($isunknown(g) || (int'(g) - e) > e / 50 + 4 || (e - int'(g)) > e / 50 + 4) begin
			failures++;
			$display("wrong value at %0t: sample %0d want %0d", $time, g, e);
		end
	endtask
	// aw and w offered together, each released once taken; bready held up
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid & bready;
			resp = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask
	task automatic rdReg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ta = arvalid & arready;
			tr = rvalid & rready;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end while (!tr);
		rready <= 1'b0;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		// reset contents, then an unmapped place
		rdReg(AEQ_VOL_OFS, rd, resp);
		checkEq(rd, 32'h000000BD);
		rdReg(AEQ_TONE_OFS, rd, resp);
		checkEq(rd, 32'h00050000);
		rdReg(8'h40, rd, resp);
		checkEq({30'h0, resp}, {30'h0, AEQ_SLVERR});
		wr(8'h40, 32'h1);
		checkEq({30'h0, resp}, {30'h0, AEQ_SLVERR});
		aeq_sample_source_inst.send(16'sd1000, res);
		checkNear(res, 0);
		// band A: K1 .75 (E=1), K2 .5 (t1, t2 low, both K >= 0), K0 0, scale on
		// its memories hold x 1000 and y 500 from the flat sample above
		wr(AEQ_BAND_OFS, 32'h40014001);
		wr(AEQ_VOL_OFS, 32'h30);
		checkEq({30'h0, resp}, {30'h0, AEQ_OKAY});
		aeq_sample_source_inst.send(16'sd1000, res);
		// A = .75*1000 + .875*1000 - .875*500, out = ((x+A)/2) halved
		checkNear(res, 547);
		wr(AEQ_BAND_OFS, 32'h40404000);
		// volume steps: 30h is 0 dB, 3Ch is -6 dB, FFh mutes
		wr(AEQ_VOL_OFS, 32'h30);
		aeq_sample_source_inst.send(16'sd1000, res);
		checkNear(res, 1000);
		wr(AEQ_VOL_OFS, 32'h3C);
		aeq_sample_source_inst.send(16'sd1000, res);
		checkNear(res, 501);
		wr(AEQ_VOL_OFS, 32'hFF);
		aeq_sample_source_inst.send(16'sd1000, res);
		checkNear(res, 0);
		// zero-cross on: new gain waits for a sign change
		wr(AEQ_VOL_OFS, 32'h30);
		aeq_sample_source_inst.send(16'sd1000, res);
		wr(AEQ_CTRL_OFS, 32'h4);
		wr(AEQ_VOL_OFS, 32'h3C);
		aeq_sample_source_inst.send(16'sd1000, res);
		checkNear(res, 1000);
		aeq_sample_source_inst.send(-16'sd1000, res);
		checkNear(-res, 501);
		wr(AEQ_CTRL_OFS, 32'h0);
		wr(AEQ_VOL_OFS, 32'h30);
		// soft mute ramps to silence over 128 samples, then back
		wr(AEQ_CTRL_OFS, 32'h1);
		repeat (130) aeq_sample_source_inst.send(16'sd1000, res);
		checkNear(res, 0);
		wr(AEQ_CTRL_OFS, 32'h0);
		repeat (130) aeq_sample_source_inst.send(16'sd1000, res);
		checkNear(res, 1000);
		// bass +6 dB: a settled DC level lies wholly in the low shelf
		wr(AEQ_TONE_OFS, 32'h050003);
		aeq_sample_source_inst.send(16'sd1000, res);
		checkNear(res, 1995);
		// hard mute over soft mute, then the square wave toggling
		wr(AEQ_CTRL_OFS, 32'h3);
		aeq_sample_source_inst.send(16'sd1000, res);
		checkNear(res, 0);
		@(negedge clk);
		sq0 = sq;
		@(negedge clk);
		checkEq({31'h0, sq0 ^ sq}, 32'h1);
		conclude();
	end
endmodule // aeq_core_test
